// ### inc/stamp_pkg.sv
// Constants and types shared by the capture time stamp logic
// Operation
// - Lead changes stamped at tick resolution, no offset
// - X.21 T/R stamped 16 bits after steady
// - Sent character starts two bits after stamp
// - Received character stamped char time plus two
// - Last sync character delayed one more character
// - First of two sync characters delayed again
// - Bit-oriented sent and received stamped alike
// - Opening flag stamped 26 bits plus zeros
// - Zero after five ones adds one bit
// - Address byte stamped 18 bits plus zeros
// - Other bytes stamped 34 bits plus zeros
// - FCS bytes stamped 24 and 16 bits
// - Closing flag stamped eight bits late
// - Tick follows speed range: 1, .5, .2, .1 ms
// - Range 65536 ticks, or 64 when disabled
// - Disabled range uses fixed aligned windows
// - Timers unusable for data captured without timing
// - Equal stamps at 64 kbps, never drift
// - Segments of 16 blocks, start and end shown
// - 2 Kbyte blocks numbered by first character
package stamp_pkg;

    // ************************************************************
    // Clock and time base
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_SLOW_US  = 1000;
    localparam int TICK_MID_US   = 500;
    localparam int TICK_FAST_US  = 200;
    localparam int TICK_TOP_US   = 100;
    localparam int TS_W          = 16;
    localparam int WIN_W         = 6;
    localparam int TICK_CNT_W    = 17;

    // ************************************************************
    // Delays in bit times
    // ************************************************************
    localparam int DLY_W            = 6;
    localparam int X21_STEADY_BITS  = 16;
    localparam int X21_CNT_W        = 5;
    localparam int COP_TX_LEAD_BITS = 2;
    localparam int COP_RX_TAIL_BITS = 2;
    localparam int BOP_OPEN_BITS    = 26;
    localparam int BOP_ADDR_BITS    = 18;
    localparam int BOP_DATA_BITS    = 34;
    localparam int BOP_FCS1_BITS    = 24;
    localparam int BOP_FCS2_BITS    = 16;
    localparam int BOP_CLOSE_BITS   = 8;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NLEAD      = 4;
    localparam int NXLINE     = 2;
    localparam int NSLOT      = 6;
    localparam int TAG_W      = 8;
    localparam int ADDR_W     = 20;
    localparam int BLK_BITS   = 11;
    localparam int SEG_BITS   = BLK_BITS + 4;

    typedef enum logic [1:0] {spd_slow, spd_mid, spd_fast, spd_top} speed_t;
    typedef enum logic [1:0] {proto_char, proto_bit, proto_x21, proto_async} proto_t;
    typedef enum logic [3:0] {
        ev_cop_rx, ev_cop_sync_last, ev_cop_sync_first, ev_bop_open, ev_bop_addr,
        ev_bop_data, ev_bop_fcs1, ev_bop_fcs2, ev_bop_close
    } ev_kind_t;

    typedef struct packed {
        speed_t     speed;
        proto_t     proto;
        logic       store_time;
        logic [3:0] char_len;
    } cfg_t;

    typedef struct packed {
        logic             valid;
        ev_kind_t         kind;
        logic [TAG_W-1:0] tag;
    } line_ev_t;

    typedef struct packed {
        logic                        valid;
        logic [NLEAD-1:0]            lead_hit;
        logic [NXLINE-1:0]           xline_hit;
        logic [NSLOT-1:0]            slot_hit;
        logic                        tx_hit;
        logic [NSLOT-1:0][TAG_W-1:0] slot_tag;
        logic [TAG_W-1:0]            tx_tag;
        logic [TS_W-1:0]             time_val;
    } stamp_t;

endpackage : stamp_pkg

// ### verilog/capture_time_stamp_unit.sv
// Capture path time stamp unit: tick counter, delayed stamps, buffer position
`timescale 1ns/10ps
module capture_time_stamp_unit #(
    parameter int TICK_SLOW_CYC = stamp_pkg::TICK_SLOW_US * 1000 / stamp_pkg::CLK_PERIOD_NS,
    parameter int TICK_MID_CYC  = stamp_pkg::TICK_MID_US * 1000 / stamp_pkg::CLK_PERIOD_NS,
    parameter int TICK_FAST_CYC = stamp_pkg::TICK_FAST_US * 1000 / stamp_pkg::CLK_PERIOD_NS,
    parameter int TICK_TOP_CYC  = stamp_pkg::TICK_TOP_US * 1000 / stamp_pkg::CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              reset_n,
    // Setup
    input  wire stamp_pkg::cfg_t                   cfg,
    input  wire logic                              capture_restart,
    // Line side
    input  wire logic                              bit_tick,
    input  wire logic                              stuff_bit,
    input  wire logic [stamp_pkg::NLEAD-1:0]       lead_in,
    input  wire logic [stamp_pkg::NXLINE-1:0]      xline_in,
    input  wire stamp_pkg::line_ev_t               line_ev,
    input  wire logic                              tx_req,
    input  wire logic [stamp_pkg::TAG_W-1:0]       tx_tag,
    output logic                                   tx_ready,
    output logic                                   tx_go,
    output logic                                   ev_ready,
    // Capture buffer side
    input  wire logic                              cap_wr,
    output stamp_pkg::stamp_t                      stamp,
    output logic                                   timers_ok,
    output logic [stamp_pkg::ADDR_W-stamp_pkg::BLK_BITS-1:0] block_num,
    output logic                                   seg_start,
    output logic                                   seg_end
);
    import stamp_pkg::*;

    typedef struct packed {
        logic             busy;
        logic [DLY_W-1:0] cnt;
        logic [TAG_W-1:0] tag;
    } slot_t;

    typedef struct packed {
        logic [TICK_CNT_W-1:0]              tick_cnt;
        logic [TS_W-1:0]                    ts;
        logic [NLEAD-1:0]                   lead;
        logic [NXLINE-1:0]                  xline;
        logic [NXLINE-1:0][X21_CNT_W-1:0]   xcnt;
        slot_t [NSLOT-1:0]                  slot;
        logic                               tx_busy;
        logic [1:0]                         tx_cnt;
        logic                               tx_go;
        logic                               timers_ok;
        logic [ADDR_W-1:0]                  addr;
        stamp_t                             stamp;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // ************************************************************
    // Delay per event kind, in bit times
    // ************************************************************
    function automatic logic [DLY_W-1:0] delay_of(input ev_kind_t k, input logic [3:0] cl);
        logic [DLY_W-1:0] c;
        c = {{(DLY_W-4){1'b0}}, cl};
        unique case (k)
            ev_cop_rx:         delay_of = c + DLY_W'(COP_RX_TAIL_BITS);
            ev_cop_sync_last:  delay_of = DLY_W'(2 * c + COP_RX_TAIL_BITS);
            ev_cop_sync_first: delay_of = DLY_W'(3 * c + COP_RX_TAIL_BITS);
            ev_bop_open:       delay_of = DLY_W'(BOP_OPEN_BITS);
            ev_bop_addr:       delay_of = DLY_W'(BOP_ADDR_BITS);
            ev_bop_data:       delay_of = DLY_W'(BOP_DATA_BITS);
            ev_bop_fcs1:       delay_of = DLY_W'(BOP_FCS1_BITS);
            ev_bop_fcs2:       delay_of = DLY_W'(BOP_FCS2_BITS);
            ev_bop_close:      delay_of = DLY_W'(BOP_CLOSE_BITS);
            default:           delay_of = DLY_W'(BOP_CLOSE_BITS);
        endcase
    endfunction : delay_of

    // ************************************************************
    // Tick limit for the selected speed range
    // ************************************************************
    logic [TICK_CNT_W-1:0] tick_lim;
    always_comb begin
        unique case (cfg.speed)
            spd_slow: tick_lim = TICK_CNT_W'(TICK_SLOW_CYC - 1);
            spd_mid:  tick_lim = TICK_CNT_W'(TICK_MID_CYC - 1);
            spd_fast: tick_lim = TICK_CNT_W'(TICK_FAST_CYC - 1);
            spd_top:  tick_lim = TICK_CNT_W'(TICK_TOP_CYC - 1);
        endcase
    end

    // Free slot search
    logic                     slot_free;
    logic [$clog2(NSLOT)-1:0] free_idx;
    always_comb begin
        slot_free = 1'b0;
        free_idx  = '0;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (!st_r.slot[i].busy) begin
                slot_free = 1'b1;
                free_idx  = ($clog2(NSLOT))'(i);
            end
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic       any_hit;
        logic       bit_adv;
        logic       xl_change;
        st_nxt  = st_r;
        any_hit = 1'b0;
        xl_change = 1'b0;
        bit_adv = bit_tick && !stuff_bit;                 // Stuffed zero holds delays
        st_nxt.stamp.valid     = 1'b0;
        st_nxt.stamp.lead_hit  = '0;
        st_nxt.stamp.xline_hit = '0;
        st_nxt.stamp.slot_hit  = '0;
        st_nxt.stamp.tx_hit    = 1'b0;
        st_nxt.tx_go           = 1'b0;

        // Free running tick counter, whole ticks only so no drift
        if (st_r.tick_cnt >= tick_lim) begin
            st_nxt.tick_cnt = '0;
            st_nxt.ts       = st_r.ts + 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
        end

        // Ordinary leads stamp on the change itself
        st_nxt.lead = lead_in;
        for (int i = 0; i < NLEAD; i++) begin
            if (lead_in[i] != st_r.lead[i]) begin
                st_nxt.stamp.lead_hit[i] = 1'b1;
            end
        end

        // T and R lines: recognised after a steady run under X.21
        st_nxt.xline = xline_in;
        for (int i = 0; i < NXLINE; i++) begin
            xl_change = xline_in[i] != st_r.xline[i];
            if (cfg.proto != proto_x21) begin
                st_nxt.xcnt[i] = X21_CNT_W'(X21_STEADY_BITS);
                if (xl_change) begin
                    st_nxt.stamp.xline_hit[i] = 1'b1;
                end
            end else if (xl_change) begin
                st_nxt.xcnt[i] = '0;
            end else if (bit_tick && st_r.xcnt[i] < X21_CNT_W'(X21_STEADY_BITS)) begin
                st_nxt.xcnt[i] = st_r.xcnt[i] + 1'b1;
                if (st_r.xcnt[i] == X21_CNT_W'(X21_STEADY_BITS - 1)) begin
                    st_nxt.stamp.xline_hit[i] = 1'b1;
                end
            end
        end

        // Delay slots: count bit times, stamp on reaching zero
        for (int i = 0; i < NSLOT; i++) begin
            if (st_r.slot[i].busy) begin
                if (st_r.slot[i].cnt == '0) begin
                    st_nxt.slot[i].busy        = 1'b0;
                    st_nxt.stamp.slot_hit[i]   = 1'b1;
                    st_nxt.stamp.slot_tag[i]   = st_r.slot[i].tag;
                end else if (bit_adv) begin
                    st_nxt.slot[i].cnt = st_r.slot[i].cnt - 1'b1;
                end
            end
        end
        if (line_ev.valid && slot_free) begin
            st_nxt.slot[free_idx].busy = 1'b1;
            st_nxt.slot[free_idx].cnt  = delay_of(line_ev.kind, cfg.char_len);
            st_nxt.slot[free_idx].tag  = line_ev.tag;
        end

        // Sent character: stamp now, launch two bit times later
        if (tx_req && !st_r.tx_busy) begin
            st_nxt.tx_busy      = 1'b1;
            st_nxt.tx_cnt       = 2'(COP_TX_LEAD_BITS);
            st_nxt.stamp.tx_hit = 1'b1;
            st_nxt.stamp.tx_tag = tx_tag;
        end else if (st_r.tx_busy && bit_tick) begin
            st_nxt.tx_cnt = st_r.tx_cnt - 1'b1;
            if (st_r.tx_cnt == 2'h1) begin
                st_nxt.tx_busy = 1'b0;
                st_nxt.tx_go   = 1'b1;
            end
        end

        // Stamp value: full count, or aligned window only
        any_hit = |st_nxt.stamp.lead_hit || |st_nxt.stamp.xline_hit
                  || |st_nxt.stamp.slot_hit || st_nxt.stamp.tx_hit;
        st_nxt.stamp.valid = any_hit;
        if (cfg.store_time) begin
            st_nxt.stamp.time_val = st_r.ts;
        end else begin
            st_nxt.stamp.time_val = {{(TS_W-WIN_W){1'b0}}, st_r.ts[WIN_W-1:0]};
        end

        // Timers lose meaning once untimed data is captured
        if (capture_restart) begin
            st_nxt.timers_ok = 1'b1;
        end
        if (any_hit && !cfg.store_time) begin
            st_nxt.timers_ok = 1'b0;
        end

        // Capture position, blocks and segments
        if (capture_restart) begin
            st_nxt.addr = '0;
        end else if (cap_wr) begin
            st_nxt.addr = st_r.addr + 1'b1;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_r           <= '0;
            st_r.timers_ok <= 1'b1;
            st_r.xcnt      <= {NXLINE{X21_CNT_W'(X21_STEADY_BITS)}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign stamp     = st_r.stamp;
    assign tx_go     = st_r.tx_go;
    assign tx_ready  = !st_r.tx_busy;
    assign ev_ready  = slot_free;
    assign timers_ok = st_r.timers_ok;
    assign block_num = st_r.addr[ADDR_W-1:BLK_BITS];
    assign seg_start = st_r.addr[SEG_BITS-1:0] == '0;
    assign seg_end   = st_r.addr[SEG_BITS-1:0] == {SEG_BITS{1'b1}};

    // ************************************************************
    // Assertions
    // ************************************************************
    a_window_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_r.stamp.valid && !$past(cfg.store_time) |-> st_r.stamp.time_val[TS_W-1:WIN_W] == '0)
        else $error("stamp outside aligned window");

    a_tick_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_r.ts != $past(st_r.ts) |-> st_r.ts == $past(st_r.ts) + 1'b1)
        else $error("tick counter jumped");

    a_tick_period: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $past(reset_n) && st_r.ts != $past(st_r.ts) |-> $past(st_r.tick_cnt) >= $past(tick_lim))
        else $error("tick came early");

    a_lead_stamp: assert property (@(posedge ref_clk) disable iff (!reset_n)
        lead_in != st_r.lead |=> st_r.stamp.valid && |st_r.stamp.lead_hit)
        else $error("lead change not stamped");

    a_x21_steady: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $past(cfg.proto) == proto_x21 && st_r.stamp.xline_hit[1]
        |-> $past(st_r.xcnt[1]) == X21_CNT_W'(X21_STEADY_BITS - 1))
        else $error("X.21 line stamped at wrong point");

    a_tx_launch: assert property (@(posedge ref_clk) disable iff (!reset_n)
        tx_req && tx_ready ##1 (!bit_tick [*2]) |=> !tx_go)
        else $error("character launched before two bit times");

    a_stuff_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_r.slot[0].busy && st_r.slot[0].cnt != '0 && bit_tick && stuff_bit
        |=> st_r.slot[0].cnt == $past(st_r.slot[0].cnt))
        else $error("stuffed zero not added to delay");

    a_timers_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_r.stamp.valid && !$past(cfg.store_time) |-> !st_r.timers_ok)
        else $error("timers still usable on untimed data");

    a_segment_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n)
        seg_end && cap_wr && !capture_restart |=> seg_start)
        else $error("segment did not restart after 32 Kbytes");

    a_slot_stamp: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_r.slot[0].busy && st_r.slot[0].cnt == '0 |=> st_r.stamp.slot_hit[0])
        else $error("delay slot expired without a stamp");

    a_lead_time: assert property (@(posedge ref_clk) disable iff (!reset_n)
        lead_in != st_r.lead && cfg.store_time |=> st_r.stamp.time_val == $past(st_r.ts))
        else $error("lead stamp carries an offset");

    a_timers_restart: assert property (@(posedge ref_clk) disable iff (!reset_n)
        capture_restart && cfg.store_time |=> timers_ok)
        else $error("timers not usable after restart");

    a_block_restart: assert property (@(posedge ref_clk) disable iff (!reset_n)
        capture_restart |=> block_num == '0 && seg_start)
        else $error("capture position not cleared");

    a_tx_go_ready: assert property (@(posedge ref_clk) disable iff (!reset_n)
        tx_go |-> tx_ready)
        else $error("launch while still busy");

endmodule : capture_time_stamp_unit

// ### sim/line_side_model.sv
// Far-side line model: bit time pulses with optional stuffed zeros
`timescale 1ns/10ps
module line_side_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Bench control
    input  wire logic       run,
    input  wire logic [7:0] period,
    input  wire logic [7:0] stuff_every,
    // Bit timing toward the block
    output logic            bit_tick,
    output logic            stuff_bit
);
    // ************************************************************
    // Bit clock, still while stopped or in reset
    // ************************************************************
    int cyc  = 0;
    int nbit = 0;
    // Quiet outputs from time zero
    initial begin
        bit_tick  = 1'h0;
        stuff_bit = 1'h0;
    end
    // One pulse a period; every stuff_every-th bit is an inserted zero
    always @(posedge ref_clk) begin
        logic tick_now;
        logic stuff_now;
        tick_now  = 1'h0;
        stuff_now = 1'h0;
        if (!reset_n || !run) begin
            cyc = 0;
        end else begin
            cyc++;
            if (cyc >= int'(period)) begin
                cyc = 0;
                nbit++;
                tick_now  = 1'h1;
                stuff_now = (stuff_every != 8'h00) && (nbit % int'(stuff_every) == 0);
            end
        end
        bit_tick  <= #1 tick_now;
        stuff_bit <= #1 stuff_now;
    end
endmodule : line_side_model

// ### sim/capture_time_stamp_unit_bench.sv
// Self-checking bench for the capture time stamp unit
`timescale 1ns/10ps
module capture_time_stamp_unit_bench;
    import stamp_pkg::*;
    // ************************************************************
    // Setup, signals and instances
    // ************************************************************
    localparam int CL      = 8;
    localparam int LIM [4] = '{20, 10, 4, 2};
    localparam int DLY [9] = '{CL + COP_RX_TAIL_BITS, 2 * CL + COP_RX_TAIL_BITS,
                               3 * CL + COP_RX_TAIL_BITS, BOP_OPEN_BITS, BOP_ADDR_BITS,
                               BOP_DATA_BITS, BOP_FCS1_BITS, BOP_FCS2_BITS, BOP_CLOSE_BITS};
    logic                          ref_clk;
    logic                          reset_n;
    cfg_t                          cfg;
    logic                          capture_restart;
    logic                          bit_tick;
    logic                          stuff_bit;
    logic [NLEAD-1:0]              lead_in;
    logic [NXLINE-1:0]             xline_in;
    line_ev_t                      line_ev;
    logic                          tx_req;
    logic [TAG_W-1:0]              tx_tag;
    logic                          tx_ready;
    logic                          tx_go;
    logic                          ev_ready;
    logic                          cap_wr;
    stamp_t                        stamp;
    logic                          timers_ok;
    logic [ADDR_W-BLK_BITS-1:0]    block_num;
    logic                          seg_start;
    logic                          seg_end;
    logic                          run;
    logic [7:0]                    period;
    logic [7:0]                    stuff_every;
    int                            fails;
    int                            tests_run;
    stamp_t                        seen_q[$];

    capture_time_stamp_unit #(
        .TICK_SLOW_CYC (LIM[0]),
        .TICK_MID_CYC  (LIM[1]),
        .TICK_FAST_CYC (LIM[2]),
        .TICK_TOP_CYC  (LIM[3])
    ) uut (
        .ref_clk, .reset_n, .cfg, .capture_restart, .bit_tick, .stuff_bit, .lead_in,
        .xline_in, .line_ev, .tx_req, .tx_tag, .tx_ready, .tx_go, .ev_ready, .cap_wr,
        .stamp, .timers_ok, .block_num, .seg_start, .seg_end
    );
    line_side_model model (
        .ref_clk, .reset_n, .run, .period, .stuff_every, .bit_tick, .stuff_bit
    );

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // Record every stamp once settled
    always @(negedge ref_clk) begin
        if (stamp.valid === 1'h1) seen_q.push_back(stamp);
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Verdict and end of run
    task close_out;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // Let n edges pass, land just after the last
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    // Hold reset three cycles with quiet line inputs
    task do_reset;
        reset_n  = 1'h0;
        lead_in  = '0;
        xline_in = '0;
        run      = 1'h0;
        step(3);
        reset_n = 1'h1;
        seen_q.delete();
    endtask : do_reset
    // Count real line bits until a stamp or a launch, bounded
    task wait_for(input logic want_go, output stamp_t s, output int nb);
        int k;
        nb = 0;
        for (k = 0; k < 4000; k++) begin
            @(negedge ref_clk);
            if (bit_tick && !stuff_bit) nb++;
            s = stamp;
            if ((want_go ? tx_go : stamp.valid) === 1'h1) break;
        end
        step(1);
        if (k == 4000) begin
            $display("BAD %0t wait ran out", $time);
            fails++;
            close_out;
        end
    endtask : wait_for

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Idle outputs after reset
    task reset_values;
        do_reset;
        chk(stamp.valid, 1'h0);
        chk({tx_ready, ev_ready, timers_ok, tx_go}, 4'he);
        chk({seg_start, block_num}, 10'h200);
        $display("Reset values done");
    endtask : reset_values
    // Two lead changes five ticks apart at every speed
    task tick_rates;
        for (int sp = 0; sp < 4; sp++) begin
            cfg.speed = speed_t'(sp);
            do_reset;
            lead_in[0] = 1'h1;
            step(LIM[sp] * 5);
            lead_in[1] = 1'h1;
            step(3);
            chk(seen_q.size(), 2);
            chk(seen_q[0].lead_hit, 4'h1);
            chk(16'(seen_q[1].time_val - seen_q[0].time_val), 16'h5);
        end
        $display("Tick rates done");
    endtask : tick_rates
    // Short aligned window once timing storage is off
    task no_timing;
        cfg = '{spd_top, proto_char, 1'h1, 4'h8};
        do_reset;
        step(50);
        lead_in[0] = 1'h1;
        step(LIM[3] * 70);
        cfg.store_time = 1'h0;
        lead_in[1] = 1'h1;
        step(3);
        chk(seen_q.size(), 2);
        chk(seen_q[1].time_val, {10'h0, 6'(seen_q[0].time_val + 16'h46)});
        chk(timers_ok, 1'h0);
        cfg.store_time = 1'h1;
        $display("Timing storage off done");
    endtask : no_timing
    // Every delayed item kind, with or without inserted zeros
    task slot_delays(input int stuff);
        stamp_t s;
        int     nb;
        for (int i = 0; i < 9; i++) begin
            run         = 1'h0;
            period      = 8'h06;
            stuff_every = 8'(stuff);
            chk(ev_ready, 1'h1);
            line_ev = '{1'h1, ev_kind_t'(i), 8'(8'h40 + i)};
            step(1);
            line_ev.valid = 1'h0;
            run = 1'h1;
            wait_for(1'h0, s, nb);
            chk(nb, DLY[i]);
            chk({s.slot_hit, s.slot_tag[0]}, {6'h01, 8'(8'h40 + i)});
        end
        $display("Slot delays done, stuff %0d", stuff);
    endtask : slot_delays
    // Send-string character starts two bits after its stamp
    task send_char;
        stamp_t s;
        int     nb;
        run    = 1'h0;
        stuff_every = 8'h00;
        tx_tag = 8'h5a;
        tx_req = 1'h1;
        step(1);
        tx_req = 1'h0;
        wait_for(1'h0, s, nb);
        chk({s.tx_hit, s.tx_tag, tx_ready}, {1'h1, 8'h5a, 1'h0});
        run = 1'h1;
        wait_for(1'h1, s, nb);
        chk(nb, COP_TX_LEAD_BITS);
        chk(tx_ready, 1'h1);
        $display("Send character done");
    endtask : send_char
    // T/R change restarts the steady count; stamp after 16 bits
    task x21_lines;
        stamp_t s;
        int     nb;
        cfg.proto = proto_x21;
        run = 1'h0;
        period = 8'h04;
        stuff_every = 8'h00;
        xline_in[1] = 1'h1;
        step(2);
        run = 1'h1;
        step(22);
        run = 1'h0;
        step(2);
        xline_in[1] = 1'h0;
        run = 1'h1;
        wait_for(1'h0, s, nb);
        chk(nb, X21_STEADY_BITS);
        chk(s.xline_hit, 2'h2);
        run = 1'h0;
        cfg.proto = proto_char;
        $display("T and R lines done");
    endtask : x21_lines
    // Block and segment position through a whole segment
    task capture_walk;
        capture_restart = 1'h1;
        step(1);
        capture_restart = 1'h0;
        step(2);
        chk({seg_start, timers_ok}, 2'h3);
        cap_wr = 1'h1;
        step(2048);
        cap_wr = 1'h0;
        step(2);
        chk({seg_start, block_num}, 10'h001);
        cap_wr = 1'h1;
        step(32767 - 2048);
        cap_wr = 1'h0;
        step(2);
        chk({seg_end, seg_start}, 2'h2);
        cap_wr = 1'h1;
        step(1);
        cap_wr = 1'h0;
        step(2);
        chk({seg_start, seg_end, block_num}, 11'h410);
        $display("Capture walk done");
    endtask : capture_walk

    // Main sequence
    initial begin
        fails = 0;
        tests_run = 0;
        ref_clk = 1'h0;
        cfg = '{spd_top, proto_char, 1'h1, 4'h8};
        {capture_restart, tx_req, cap_wr, tx_tag} = '0;
        line_ev = '0;
        period = 8'h06;
        stuff_every = 8'h00;
        reset_values;
        tick_rates;
        no_timing;
        slot_delays(0);
        slot_delays(5);
        send_char;
        x21_lines;
        capture_walk;
        close_out;
    end
endmodule : capture_time_stamp_unit_bench
